// ---- rtl/edge_detect.sv ----
`timescale 1ns/100ps
module edge_detect
   import intctl_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   resetn,
   input  wire logic [NUM_EXT_IRQ-1:0] irq_in,
   input  wire logic [NUM_EXT_IRQ-1:0] polarity,
   output logic      [NUM_EXT_IRQ-1:0] edge_pulse
);
   logic [NUM_EXT_IRQ-1:0] prev_reg;

   // Previous sample per input; reset to idle low.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         prev_reg <= '0;
      end else begin
         prev_reg <= irq_in;
      end
   end

   // Each input picks rising or falling edge from its own bit.
   genvar i;
   generate
      for (i = 0; i < NUM_EXT_IRQ; i++) begin : g_edge
         always_ff @(posedge clk) begin
            if (!resetn) begin
               edge_pulse[i] <= 1'b0;
            end else if (polarity[i]) begin
               edge_pulse[i] <= irq_in[i] & ~prev_reg[i];
            end else begin
               edge_pulse[i] <= ~irq_in[i] & prev_reg[i];
            end
         end
      end
   endgenerate
endmodule : edge_detect

// ---- rtl/intctl_pkg.sv ----
package intctl_pkg;

   // Control register byte offset; the alias words follow it.
   localparam logic [11:0] CTRL_OFS        = 12'h000;
   localparam logic [11:0] NMI_CTRL_OFS    = 12'h010;
   localparam logic [3:0]  ALIAS_CLR       = 4'h4;
   localparam logic [3:0]  ALIAS_SET       = 4'h8;
   localparam logic [3:0]  ALIAS_INV       = 4'hc;

   // Control register field layout.
   localparam int          KEY_LSB         = 24;
   localparam logic [7:0]  NMI_KEY_VALUE   = 8'h4e;
   localparam int          MODE_SEL_BIT    = 12;
   localparam int          THRESH_LSB      = 8;
   localparam int          NUM_EXT_IRQ     = 5;
   localparam logic [31:0] CTRL_IMPL_MASK  = 32'hff00171f;
   localparam logic [31:0] CTRL_RESET      = 32'h00000000;
   localparam int          NMI_FLAG_BIT    = 19;

   // Vector offset registers: 18-bit offset, bit 0 not stored.
   localparam int          NUM_VEC_OFS     = 13;
   localparam logic [31:0] VEC_OFS_MASK    = 32'h0003fffe;
   localparam logic [31:0] VEC_OFS_RESET   = 32'h00000000;
   localparam logic [11:0] VEC_OFS_ADDR [NUM_VEC_OFS] = '{
      12'h7a0, 12'h7a4, 12'h7a8, 12'h7ac, 12'h7b0, 12'h7b4,
      12'h7c8, 12'h7cc, 12'h7d0, 12'h7d4, 12'h7d8, 12'h7dc, 12'h7f0};
   // One marks a crypto-only entry (indices 8, 10, 11, 12).
   localparam logic [NUM_VEC_OFS-1:0] VEC_OFS_CRYPTO = 13'h1d00;
   localparam logic [NUM_VEC_OFS-1:0] VEC_OFS_CAN    = 13'h0000;

   typedef enum logic [1:0] {OP_WRITE, OP_CLR, OP_SET, OP_INV} wr_op_t;

   typedef struct packed {
      logic        multi_vector_select;
      logic [2:0]  proximity_timer_threshold;
      logic [4:0]  ext_irq_polarity;
   } ctrl_view_t;

endpackage : intctl_pkg

// ---- rtl/intctl_regs.sv ----
`timescale 1ns/100ps
// What this block does
// - Control registers answer clear, set, invert aliases at base plus 4, 8, 12.
// - Key 0x4E written to bits 31-24 raises software NMI, sets NMI flag.
// - Control bit 12 selects multi-vector mode; zero means single vector.
// - Threshold field bits 10-8: zero disables, N admits priority 1 to N.
// - Bits 4-0 pick rising (1) or falling (0) edge per external input.
// - Unimplemented control bits read zero and ignore writes.
// - All implemented control fields reset to zero.
// - Crypto or CAN offset registers vanish on variants lacking that module.
module intctl_regs
   import intctl_pkg::*;
#(
   parameter bit HAS_CRYPTO = 1'b1,
   parameter bit HAS_CAN    = 1'b1
)(
   input  wire logic                   clk,
   input  wire logic                   resetn,
   input  wire logic [11:0]            addr,
   input  wire logic [31:0]            wdata,
   input  wire logic                   wr_en,
   input  wire logic                   rd_en,
   output logic      [31:0]            rdata,
   input  wire logic [NUM_EXT_IRQ-1:0] ext_irq_in,
   input  wire logic                   irq_valid,
   input  wire logic [2:0]             irq_priority,
   output logic      [NUM_EXT_IRQ-1:0] ext_irq_edge,
   output logic                        prox_timer_start,
   output logic                        soft_nmi,
   output logic                        multi_vector_mode,
   output logic      [17:0]            vector_address_offset [NUM_VEC_OFS]
);
   logic [31:0] interrupt_global_control_reg;
   logic [31:0] ctrl_next;
   logic        general_nmi_flag_reg;
   logic [31:0] nmi_ctrl_next;
   logic [31:0] vector_offset_regs [NUM_VEC_OFS];
   logic [NUM_VEC_OFS-1:0] ofs_present;
   logic [NUM_VEC_OFS-1:0] ofs_hit;
   logic        ctrl_hit;
   logic        nmi_hit;
   wr_op_t      ctrl_op;
   wr_op_t      nmi_op;
   logic        key_write;
   logic        nmi_clear;
   ctrl_view_t  view;
   logic [31:0] rd_mux;

   // Alias decode on the low nibble of each 16-byte control group.
   function automatic wr_op_t alias_op(input logic [3:0] low);
      unique case (low)
         ALIAS_CLR: alias_op = OP_CLR;
         ALIAS_SET: alias_op = OP_SET;
         ALIAS_INV: alias_op = OP_INV;
         default:   alias_op = OP_WRITE;
      endcase
   endfunction : alias_op

   // Apply write, clear, set or invert under an implemented-bit mask.
   function automatic logic [31:0] apply_op(input wr_op_t op,
                                            input logic [31:0] cur,
                                            input logic [31:0] wd,
                                            input logic [31:0] mask);
      logic [31:0] r;
      r = cur;
      unique case (op)
         OP_WRITE: r = wd;
         OP_CLR:   r = cur & ~wd;
         OP_SET:   r = cur | wd;
         OP_INV:   r = cur ^ wd;
      endcase
      apply_op = r & mask;
   endfunction : apply_op

   assign ctrl_hit = (addr[11:4] == CTRL_OFS[11:4]) && (addr[1:0] == 2'b00);
   assign nmi_hit  = (addr[11:4] == NMI_CTRL_OFS[11:4]) &&
                     (addr[1:0] == 2'b00);
   assign ctrl_op  = alias_op(addr[3:0]);
   assign nmi_op   = alias_op(addr[3:0]);
   assign ctrl_next = apply_op(ctrl_op, interrupt_global_control_reg,
                               wdata, CTRL_IMPL_MASK);
   assign nmi_ctrl_next = apply_op(nmi_op,
                                   {12'h000, general_nmi_flag_reg, 19'h0},
                                   wdata, 32'h1 << NMI_FLAG_BIT);

   // A key counts only when the resulting key field holds the code.
   assign key_write = wr_en && ctrl_hit &&
      (ctrl_next[KEY_LSB +: 8] == NMI_KEY_VALUE);
   assign nmi_clear = wr_en && nmi_hit && !nmi_ctrl_next[NMI_FLAG_BIT];

   // Offset register presence per variant, and address match.
   genvar i;
   generate
      for (i = 0; i < NUM_VEC_OFS; i++) begin : g_ofs
         assign ofs_present[i] = (HAS_CRYPTO || !VEC_OFS_CRYPTO[i]) &&
                                 (HAS_CAN || !VEC_OFS_CAN[i]);
         assign ofs_hit[i] = ofs_present[i] && (addr == VEC_OFS_ADDR[i]);
         always_ff @(posedge clk) begin
            if (!resetn) begin
               vector_offset_regs[i] <= VEC_OFS_RESET;
            end else if (wr_en && ofs_hit[i]) begin
               vector_offset_regs[i] <= wdata & VEC_OFS_MASK;
            end
         end
         assign vector_address_offset[i] = vector_offset_regs[i][17:0];
      end
   endgenerate

   // Control register; everything implemented resets to zero.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         interrupt_global_control_reg <= CTRL_RESET;
      end else if (wr_en && ctrl_hit) begin
         interrupt_global_control_reg <= ctrl_next;
      end
   end

   // NMI flag: a key write beats a software clear in the same cycle.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         general_nmi_flag_reg <= 1'b0;
      end else if (key_write) begin
         general_nmi_flag_reg <= 1'b1;
      end else if (nmi_clear) begin
         general_nmi_flag_reg <= 1'b0;
      end
   end

   // Software NMI pulse to the core, registered.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         soft_nmi <= 1'b0;
      end else begin
         soft_nmi <= key_write;
      end
   end

   assign view = '{
      multi_vector_select:       interrupt_global_control_reg[MODE_SEL_BIT],
      proximity_timer_threshold: interrupt_global_control_reg[THRESH_LSB +: 3],
      ext_irq_polarity:          interrupt_global_control_reg[4:0]};

   // Mode output comes from a flop to keep top outputs registered.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         multi_vector_mode <= 1'b0;
      end else begin
         multi_vector_mode <= view.multi_vector_select;
      end
   end

   edge_detect u_edge (
      .clk        (clk),
      .resetn     (resetn),
      .irq_in     (ext_irq_in),
      .polarity   (view.ext_irq_polarity),
      .edge_pulse (ext_irq_edge)
   );

   prox_gate u_prox (
      .clk          (clk),
      .resetn       (resetn),
      .irq_valid    (irq_valid),
      .irq_priority (irq_priority),
      .threshold    (view.proximity_timer_threshold),
      .timer_start  (prox_timer_start)
   );

   // Read mux; unmapped or absent addresses read zero.
   always_comb begin
      rd_mux = 32'h0;
      if (addr == CTRL_OFS) begin
         rd_mux = interrupt_global_control_reg & CTRL_IMPL_MASK;
      end else if (addr == NMI_CTRL_OFS) begin
         rd_mux = {12'h000, general_nmi_flag_reg, 19'h0};
      end else begin
         for (int k = 0; k < NUM_VEC_OFS; k++) begin
            if (ofs_hit[k]) begin
               rd_mux = vector_offset_regs[k];
            end
         end
      end
   end

   // Read data stand only in the cycle after the strobe.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdata <= 32'h0;
      end else if (rd_en) begin
         rdata <= rd_mux;
      end else begin
         rdata <= 32'h0;
      end
   end
endmodule : intctl_regs

// ---- rtl/prox_gate.sv ----
`timescale 1ns/100ps
module prox_gate
   import intctl_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       irq_valid,
   input  wire logic [2:0] irq_priority,
   input  wire logic [2:0] threshold,
   output logic            timer_start
);
   // Zero threshold disables; otherwise priority 1 up to N starts it.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         timer_start <= 1'b0;
      end else begin
         timer_start <= irq_valid && (threshold != 3'h0) &&
                        (irq_priority != 3'h0) &&
                        (irq_priority <= threshold);
      end
   end
endmodule : prox_gate

// ---- testbench/core_model.sv ----
`timescale 1ns/100ps
// Stands in for the core: it raises requests and counts nmi pulses.
module core_model (
   input  wire logic clk,
   input  wire logic soft_nmi,
   input  wire logic prox_timer_start,
   output logic      irq_valid,
   output logic [2:0] irq_priority,
   output int        nmi_count
);
   initial begin
      irq_valid = 1'b0;
      irq_priority = 3'h0;
      nmi_count = 0;
   end
   // Each registered pulse is one taken nmi.
   always @(posedge clk) if (soft_nmi === 1'b1) nmi_count++;
   // One-cycle request; the priority is scrambled once it is released.
   task automatic request(input logic [2:0] p, output logic st);
      @(posedge clk);
      irq_valid <= 1'b1;
      irq_priority <= p;
      @(posedge clk);
      irq_valid <= 1'b0;
      irq_priority <= ~p;
      #1 st = prox_timer_start;
   endtask : request
endmodule : core_model

// ---- testbench/intctl_regs_monitor.sv ----
`timescale 1ns/100ps
module intctl_regs_monitor
   import intctl_pkg::*;
(
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic [11:0] addr,
   input wire logic [31:0] wdata,
   input wire logic        wr_en,
   input wire logic        rd_en,
   input wire logic [31:0] rdata,
   input wire logic        irq_valid,
   input wire logic [2:0]  irq_priority,
   input wire logic        prox_timer_start,
   input wire logic        soft_nmi,
   input wire logic        multi_vector_mode
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // Writes to the control word and to its three alias words.
   wire wr_ctrl = wr_en && addr == CTRL_OFS;
   wire wr_clr  = wr_en && addr == 12'h004;
   wire wr_set  = wr_en && addr == 12'h008;
   wire wr_inv  = wr_en && addr == 12'h00c;
   wire key_ok  = wdata[31:24] == NMI_KEY_VALUE;
   AST_KEY_NMI: assert property (wr_ctrl && key_ok |=> soft_nmi)
      else $error("key write gave no nmi");
   AST_BAD_KEY: assert property (wr_ctrl && !key_ok |=> !soft_nmi)
      else $error("wrong key gave nmi");
   AST_RD_UNIMPL: assert property (
      rd_en && addr == CTRL_OFS |=> (rdata & ~CTRL_IMPL_MASK) == 32'h0)
      else $error("unused control bits read nonzero");
   AST_MODE_WR: assert property (
      wr_ctrl |=> ##1 multi_vector_mode == $past(wdata[12], 2))
      else $error("mode select does not follow write");
   AST_MODE_CLR: assert property (
      wr_clr && wdata[12] |=> ##1 !multi_vector_mode)
      else $error("clear alias missed");
   AST_MODE_SET: assert property (
      wr_set && wdata[12] |=> ##1 multi_vector_mode)
      else $error("set alias missed");
   AST_MODE_INV: assert property (
      wr_inv && wdata[12] |=> ##1 multi_vector_mode != $past(multi_vector_mode))
      else $error("invert alias missed");
   AST_PROX_CAUSE: assert property (
      prox_timer_start |-> $past(irq_valid) && $past(irq_priority) != 3'h0)
      else $error("timer start without a request");
   AST_RESET_ZERO: assert property (disable iff (1'b0)
      !resetn |=> !soft_nmi && !multi_vector_mode && rdata == 32'h0)
      else $error("outputs not cleared by reset");
   cover property (wr_ctrl && key_ok);
   cover property (prox_timer_start);
   cover property (wr_inv);
endmodule : intctl_regs_monitor

bind intctl_regs intctl_regs_monitor i_mon (.clk(clk), .resetn(resetn),
   .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
   .irq_valid(irq_valid), .irq_priority(irq_priority),
   .prox_timer_start(prox_timer_start), .soft_nmi(soft_nmi),
   .multi_vector_mode(multi_vector_mode));

// ---- testbench/intctl_regs_tb.sv ----
`timescale 1ns/100ps
module intctl_regs_tb
   import intctl_pkg::*;
;
   logic        clk = 1'b0;
   logic        resetn, wr_en, rd_en, irq_valid, prox_timer_start;
   logic        soft_nmi, multi_vector_mode;
   logic [11:0] addr;
   logic [31:0] wdata, rdata;
   logic [4:0]  ext_irq_in, ext_irq_edge;
   logic [2:0]  irq_priority;
   logic [17:0] ofs_view [NUM_VEC_OFS];
   logic [31:0] rdata_lite;
   int          num_errors = 0, check_count = 0, cyc = 0, nmi_count;
   always #25 clk = ~clk;
   intctl_regs i_dut (.clk(clk), .resetn(resetn), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
      .ext_irq_in(ext_irq_in), .irq_valid(irq_valid),
      .irq_priority(irq_priority), .ext_irq_edge(ext_irq_edge),
      .prox_timer_start(prox_timer_start), .soft_nmi(soft_nmi),
      .multi_vector_mode(multi_vector_mode),
      .vector_address_offset(ofs_view));
   // Variant without the crypto and CAN offset words, on the same bus.
   intctl_regs #(.HAS_CRYPTO(1'b0), .HAS_CAN(1'b0)) i_lite (.clk(clk),
      .resetn(resetn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata(rdata_lite), .ext_irq_in(ext_irq_in),
      .irq_valid(irq_valid), .irq_priority(irq_priority),
      .ext_irq_edge(), .prox_timer_start(), .soft_nmi(),
      .multi_vector_mode(), .vector_address_offset());
   core_model i_core (.clk(clk), .soft_nmi(soft_nmi),
      .prox_timer_start(prox_timer_start), .irq_valid(irq_valid),
      .irq_priority(irq_priority), .nmi_count(nmi_count));
   task complete_run;
      if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : complete_run
   task chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe.
   task rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge clk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 chk(rdata, e);
   endtask : rd
   // Aliases work on the stored word; unused bits never take a one.
   task t_alias;
      wr(CTRL_OFS, 32'hffff_ffff);
      rd(CTRL_OFS, CTRL_IMPL_MASK);
      wr(12'h004, 32'h0000_1015);
      rd(CTRL_OFS, 32'hff00_070a);
      wr(12'h008, 32'h00fe_e8e0);
      rd(CTRL_OFS, 32'hff00_070a);
      wr(12'h00c, 32'h0000_101f);
      rd(CTRL_OFS, 32'hff00_1715);
      chk(32'(multi_vector_mode), 32'h1);
      chk(nmi_count, 0);
   endtask : t_alias
   // Right key, wrong key, then a key built through the set alias.
   task t_key;
      wr(CTRL_OFS, 32'h4e00_1000);
      repeat (3) @(posedge clk);
      chk(nmi_count, 1);
      rd(NMI_CTRL_OFS, 32'h0008_0000);
      wr(NMI_CTRL_OFS, 32'h0);
      wr(CTRL_OFS, 32'h4f00_0000);
      repeat (3) @(posedge clk);
      chk(nmi_count, 1);
      rd(NMI_CTRL_OFS, 32'h0);
      wr(12'h004, 32'hff00_0000);
      wr(12'h008, 32'h4e00_0000);
      repeat (3) @(posedge clk);
      chk(nmi_count, 2);
   endtask : t_key
   task t_prox;
      logic st;
      for (int t = 0; t < 8; t++) begin
         wr(CTRL_OFS, 32'(t) << THRESH_LSB);
         for (int p = 0; p < 8; p++) begin
            i_core.request(3'(p), st);
            chk(32'(st), 32'(t != 0 && p != 0 && p <= t));
         end
      end
   endtask : t_prox
   // Edges are gathered over a short window so latency does not matter.
   task edge_try(input logic [4:0] lvl, input logic [4:0] e);
      logic [4:0] acc;
      acc = 5'h00;
      @(posedge clk);
      ext_irq_in <= lvl;
      repeat (4) begin
         @(posedge clk);
         #1 acc |= ext_irq_edge;
      end
      chk(32'(acc), 32'(e));
   endtask : edge_try
   task t_edge;
      wr(CTRL_OFS, 32'h0000_0015);
      edge_try(5'h1f, 5'h15);
      edge_try(5'h00, 5'h0a);
      wr(CTRL_OFS, 32'h0000_000a);
      edge_try(5'h1f, 5'h0a);
      edge_try(5'h00, 5'h15);
   endtask : t_edge
   // Offset words have no alias words; holes read zero.
   task t_vector_address_offset;
      wr(12'h7a0, 32'hffff_ffff);
      wr(12'h7a4, 32'h0);
      rd(12'h7a0, VEC_OFS_MASK);
      chk(rdata_lite, 32'h0003_fffe);
      chk(32'(ofs_view[0]), 32'h0003_fffe);
      wr(12'h7f0, 32'h0001_2345);
      rd(12'h7f0, 32'h0001_2344);
      chk(rdata_lite, 32'h0);
      wr(12'h7e0, 32'hffff_ffff);
      rd(12'h7e0, 32'h0);
   endtask : t_vector_address_offset
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         complete_run;
      end
   end
   initial begin
      resetn = 1'b0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 12'h000;
      wdata = 32'h0;
      ext_irq_in = 5'h00;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      rd(CTRL_OFS, CTRL_RESET);
      rd(NMI_CTRL_OFS, 32'h0);
      t_alias;
      t_key;
      t_prox;
      t_edge;
      t_vector_address_offset;
      complete_run;
   end
endmodule : intctl_regs_tb
